// File: design/asrc_defs.svh
`ifndef ASRC_DEFS_SVH
`define ASRC_DEFS_SVH
// Link word layout
`define ASRC_CH_W 14
`define ASRC_CMD_W 16
`define ASRC_CRC_POLY 8'h07
`define ASRC_CRC_INV 8'hff
`define ASRC_CMD_WR 15
// Device register addresses
`define ASRC_A_CFG1 3'h1
`define ASRC_A_CFG2 3'h2
`define ASRC_A_ALERT 3'h3
`define ASRC_A_LOW 3'h4
`define ASRC_A_HIGH 3'h5
// Device register fields and reset values
`define ASRC_CFG1_CRCW 5
`define ASRC_CFG1_CRCR 4
`define ASRC_LANE_ONE 2'h1
`define ASRC_ALERT_CRCW 9
`define ASRC_RST_CFG 12'h000
`define ASRC_RST_LOW 12'h800
`define ASRC_RST_HIGH 12'h7ff
// Timing
`define ASRC_CLK_NS 25
`define ASRC_CONV_NS 500
`define ASRC_HALF 8
// Frame clock counts
`define ASRC_N_TWO 7'd28
`define ASRC_N_ONE 7'd56
`define ASRC_N_CRC 7'd8
`define ASRC_N_RES_TWO 7'd4
`define ASRC_N_RES_ONE 7'd8
// Host register map (byte addresses)
`define ASRC_R_CMD 8'h00
`define ASRC_R_CFG 8'h04
`define ASRC_R_STAT 8'h08
`define ASRC_R_RXA_HI 8'h0c
`define ASRC_R_RXA_LO 8'h10
`define ASRC_R_RXB 8'h14
`define ASRC_HC_CRCW 0
`define ASRC_HC_CRCR 1
`define ASRC_HC_ONE 2
`define ASRC_HC_RES 3
`define ASRC_RESP_OK 2'h0
`define ASRC_RESP_ERR 2'h2
`endif

// File: design/asrc_pkg.sv
`include "asrc_defs.svh"
package asrc_pkg;
  typedef enum logic [1:0] {ASRC_IDLE, ASRC_RUN, ASRC_GAP} asrc_hstate_t;

  // Checksum over a left-aligned message of len bits
  function automatic logic [7:0] asrc_crc8(input logic [55:0] msg,
                                           input int unsigned len);
    logic [7:0] crc;
    logic [55:0] m;
    logic fb;
    m = msg ^ {`ASRC_CRC_INV, 48'h0};
    crc = 8'h00;
    fb = 1'b0;
    for (int i = 0; i < 56; i++)
    begin
      if (i < len)
      begin
        fb = crc[7] ^ m[55-i];
        crc = {crc[6:0], 1'b0} ^ (fb ? `ASRC_CRC_POLY : 8'h00);
      end
    end
    return crc;
  endfunction
endpackage

// File: design/asrc_link_if.sv
`timescale 1ns/100ps
interface asrc_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic serial_out_first;
  logic serial_out_first_oe;
  logic serial_out_second;
  logic serial_out_second_oe;
  wire first_pin;
  wire second_pin;
  // Released lane shows the inverted bit
  assign first_pin = serial_out_first_oe ? serial_out_first
    : ~serial_out_first;
  assign second_pin = serial_out_second_oe ? serial_out_second
    : ~serial_out_second;
  modport dev (input cs_n, input sclk, input sdi,
    output serial_out_first, output serial_out_first_oe,
    output serial_out_second, output serial_out_second_oe);
  modport host (output cs_n, output sclk, output sdi,
    input first_pin, input second_pin);
endinterface

// File: design/asrc_device.sv
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "asrc_defs.svh"
// Contract
// - Two-lane: A,C first lane; B,D second
// - Single-lane: A,B,C,D on first lane
// - Host picks single lane only when slow
// - Frame outputs previous conversion result
// - Second pulse after conversion reads fresh result
// - Read: D15 low, address D14-D12
// - Read data returns in following frame
// - Write: D15 high, address, twelve data bits
// - Write lasts 16 bits, 24 with checksum
// - Separate read and write checksum enables
// - Read checksum appended on first lane
// - Read checksum works in every lane mode
// - Enabling write checksum needs valid checksum
// - Checked writes without valid checksum discarded
// - Generator x^8+x^2+x+1
// - Four results concatenated, A first
// - Leading eight bits complemented
// - Remainder after eight zero bits appended
// - Frame start samples inputs, starts conversion
// - First bit at frame start, shift on rise
// - Host clocks per frame per mode
// - Reads of 0, 6, 7 ignored
module asrc_device
  import asrc_pkg::*;
#(
  parameter int CONV_NS = `ASRC_CONV_NS
)(
  input wire logic aclk,
  input wire logic aresetn,
  asrc_link_if.dev link,
  input wire logic [`ASRC_CH_W-1:0] ch_a,
  input wire logic [`ASRC_CH_W-1:0] ch_b,
  input wire logic [`ASRC_CH_W-1:0] ch_c,
  input wire logic [`ASRC_CH_W-1:0] ch_d,
  output logic sample_strobe,
  output logic result_ready,
  output logic write_reject
);
  localparam int CONV_CYC = (CONV_NS + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS;

  initial
  begin
    if (CONV_CYC < 1 || CONV_CYC > 4095)
      $error("conversion time out of range");
  end

  logic [2:0] cs_s;
  logic [2:0] sclk_s;
  logic [1:0] sdi_s;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic [11:0] cfg1;
  logic [11:0] cfg2;
  logic [11:0] thr_low;
  logic [11:0] thr_high;
  logic crcw_fail;
  logic [4*`ASRC_CH_W-1:0] held;
  logic [4*`ASRC_CH_W-1:0] result;
  logic [11:0] conv_cnt;
  logic [23:0] rx_sh;
  logic [5:0] rx_cnt;
  logic [15:0] cmd;
  logic [7:0] crc_in;
  logic rd_pend;
  logic [2:0] rd_addr;
  logic [63:0] sh1;
  logic [27:0] sh2;
  logic oe1;
  logic oe2;

  // Pin synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cs_s <= 3'h7;
      sclk_s <= 3'h0;
      sdi_s <= 2'h0;
    end
    else
    begin
      cs_s <= {cs_s[1:0], link.cs_n};
      sclk_s <= {sclk_s[1:0], link.sclk};
      sdi_s <= {sdi_s[0], link.sdi};
    end
  end

  assign cs_fall = cs_s[2] & ~cs_s[1];
  assign cs_rise = ~cs_s[2] & cs_s[1];
  assign sclk_rise = ~sclk_s[2] & sclk_s[1] & ~cs_s[1];

  // Conversion timer on internal clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      held <= '0;
      result <= '0;
      conv_cnt <= 12'h000;
      sample_strobe <= 1'b0;
      result_ready <= 1'b0;
    end
    else
    begin
      sample_strobe <= cs_fall;
      result_ready <= 1'b0;
      if (cs_fall)
      begin
        held <= {ch_a, ch_b, ch_c, ch_d};
        conv_cnt <= 12'(CONV_CYC);
      end
      else if (conv_cnt == 12'h001)
      begin
        result <= held;
        result_ready <= 1'b1;
        conv_cnt <= 12'h000;
      end
      else if (conv_cnt != 12'h000)
        conv_cnt <= conv_cnt - 12'h001;
    end
  end

  // Command receiver, sampled on serial clock rise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_sh <= 24'h0;
      rx_cnt <= 6'h0;
      cmd <= 16'h0;
      crc_in <= 8'h0;
    end
    else if (cs_fall)
      rx_cnt <= 6'h0;
    else if (sclk_rise)
    begin
      rx_sh <= {rx_sh[22:0], sdi_s[1]};
      if (rx_cnt != 6'h3f)
        rx_cnt <= rx_cnt + 6'h01;
      if (rx_cnt == 6'd15)
        cmd <= {rx_sh[14:0], sdi_s[1]};
      if (rx_cnt == 6'd23)
        crc_in <= {rx_sh[6:0], sdi_s[1]};
    end
  end

  logic wr;
  logic [2:0] addr;
  logic [11:0] data;
  logic need_crc;
  logic crc_ok;
  logic wr_ok;
  assign wr = cmd[`ASRC_CMD_WR];
  assign addr = cmd[14:12];
  assign data = cmd[11:0];
  assign need_crc = cfg1[`ASRC_CFG1_CRCW]
    | (addr == `ASRC_A_CFG1 && data[`ASRC_CFG1_CRCW]);
  assign crc_ok = (rx_cnt >= 6'd24)
    && crc_in == asrc_crc8({cmd, 40'h0}, 16);
  assign wr_ok = wr && (rx_cnt >= 6'd16) && (!need_crc || crc_ok);

  // Register writes at frame end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg1 <= `ASRC_RST_CFG;
      cfg2 <= `ASRC_RST_CFG;
      thr_low <= `ASRC_RST_LOW;
      thr_high <= `ASRC_RST_HIGH;
      crcw_fail <= 1'b0;
      write_reject <= 1'b0;
    end
    else
    begin
      write_reject <= 1'b0;
      if (cs_rise && wr && rx_cnt >= 6'd16 && !wr_ok)
      begin
        crcw_fail <= 1'b1;
        write_reject <= 1'b1;
      end
      if (cs_rise && wr_ok)
      begin
        unique case (addr)
          `ASRC_A_CFG1: cfg1 <= data;
          `ASRC_A_CFG2: cfg2 <= data;
          `ASRC_A_LOW: thr_low <= data;
          `ASRC_A_HIGH: thr_high <= data;
          default: ;
        endcase
      end
    end
  end

  // Pending register read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_pend <= 1'b0;
      rd_addr <= 3'h0;
    end
    else if (cs_fall)
      rd_pend <= 1'b0;
    else if (cs_rise && !wr && rx_cnt >= 6'd16)
    begin
      rd_pend <= (addr >= `ASRC_A_CFG1 && addr <= `ASRC_A_HIGH);
      rd_addr <= addr;
    end
  end

  logic [11:0] rd_val;
  logic [15:0] rd_word;
  logic [7:0] conv_crc;
  logic [7:0] reg_crc;
  logic crcr;
  logic single;
  always_comb
  begin
    unique case (rd_addr)
      `ASRC_A_CFG1: rd_val = cfg1;
      `ASRC_A_CFG2: rd_val = cfg2;
      `ASRC_A_ALERT: rd_val = 12'(crcw_fail) << `ASRC_ALERT_CRCW;
      `ASRC_A_LOW: rd_val = thr_low;
      `ASRC_A_HIGH: rd_val = thr_high;
      default: rd_val = 12'h000;
    endcase
  end
  assign rd_word = {1'b0, rd_addr, rd_val};
  assign conv_crc = asrc_crc8(result, 56);
  assign reg_crc = asrc_crc8({rd_word, 40'h0}, 16);
  assign crcr = cfg1[`ASRC_CFG1_CRCR];
  assign single = cfg2[9:8] == `ASRC_LANE_ONE;

  // Output lanes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sh1 <= 64'h0;
      sh2 <= 28'h0;
      oe1 <= 1'b0;
      oe2 <= 1'b0;
    end
    else if (cs_fall)
    begin
      oe1 <= 1'b1;
      oe2 <= !single;
      sh2 <= {result[41:28], result[13:0]};
      if (rd_pend)
        sh1 <= {rd_word, crcr ? reg_crc : 8'h00, 40'h0};
      else if (single)
        sh1 <= {result, crcr ? conv_crc : 8'h00};
      else
        sh1 <= {result[55:42], result[27:14],
          crcr ? conv_crc : 8'h00, 28'h0};
    end
    else if (cs_rise)
    begin
      oe1 <= 1'b0;
      oe2 <= 1'b0;
    end
    else if (sclk_rise)
    begin
      sh1 <= {sh1[62:0], 1'b0};
      sh2 <= {sh2[26:0], 1'b0};
    end
  end

  assign link.serial_out_first = sh1[63];
  assign link.serial_out_second = sh2[27];
  assign link.serial_out_first_oe = oe1;
  assign link.serial_out_second_oe = oe2;
endmodule

// File: design/asrc_host.sv
`timescale 1ns/100ps
`include "asrc_defs.svh"
module asrc_host
  import asrc_pkg::*;
#(
  parameter int HALF = `ASRC_HALF
)(
  input wire logic aclk,
  input wire logic aresetn,
  asrc_link_if.host link,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // Gap count must fit the 8-bit divider
  if (HALF < 8 || HALF > 127)
    $error("HALF out of range");

  asrc_hstate_t state;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  logic [3:0] cfg;
  logic [15:0] cmd;
  logic go;
  logic busy;
  logic [1:0] first_s;
  logic [1:0] second_s;
  logic [7:0] div;
  logic [6:0] cnt;
  logic [6:0] n_clk;
  logic [23:0] tx;
  logic [63:0] rxa;
  logic [31:0] rxb;
  logic cs_n;
  logic sclk;
  logic sdi;

  // AXI write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h0;
      w_s <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `ASRC_RESP_OK;
      cfg <= 4'h0;
      cmd <= 16'h0;
      go <= 1'b0;
    end
    else
    begin
      go <= 1'b0;
      if (awvalid && awready)
      begin
        aw_got <= 1'b1;
        aw_a <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_got <= 1'b1;
        w_d <= wdata;
        w_s <= wstrb;
        wready <= 1'b0;
      end
      if (aw_got && w_got && !bvalid)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `ASRC_RESP_OK;
        if (aw_a == `ASRC_R_CMD && !busy && !go)
        begin
          cmd <= w_d[15:0];
          go <= 1'b1;
        end
        else if (aw_a == `ASRC_R_CFG && w_s[0])
          cfg <= w_d[3:0];
        else if (aw_a != `ASRC_R_CMD && aw_a != `ASRC_R_CFG)
          bresp <= `ASRC_RESP_ERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // AXI read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `ASRC_RESP_OK;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `ASRC_RESP_OK;
      unique case (araddr)
        `ASRC_R_CMD: rdata <= {16'h0, cmd};
        `ASRC_R_CFG: rdata <= {28'h0, cfg};
        `ASRC_R_STAT: rdata <= {31'h0, busy};
        `ASRC_R_RXA_HI: rdata <= rxa[63:32];
        `ASRC_R_RXA_LO: rdata <= rxa[31:0];
        `ASRC_R_RXB: rdata <= rxb;
        default:
        begin
          rdata <= 32'h0;
          rresp <= `ASRC_RESP_ERR;
        end
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Lane synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      first_s <= 2'h0;
      second_s <= 2'h0;
    end
    else
    begin
      first_s <= {first_s[0], link.first_pin};
      second_s <= {second_s[0], link.second_pin};
    end
  end

  // Frame engine with divided serial clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ASRC_IDLE;
      busy <= 1'b0;
      cs_n <= 1'b1;
      sclk <= 1'b0;
      sdi <= 1'b0;
      div <= 8'h00;
      cnt <= 7'h00;
      n_clk <= 7'h00;
      tx <= 24'h0;
      rxa <= 64'h0;
      rxb <= 32'h0;
    end
    else
    begin
      unique case (state)
        ASRC_IDLE:
        begin
          if (go)
          begin
            state <= ASRC_RUN;
            busy <= 1'b1;
            cs_n <= 1'b0;
            div <= 8'h00;
            cnt <= 7'h00;
            sdi <= cmd[15];
            tx <= {cmd, (cfg[`ASRC_HC_CRCW] && cmd[15]) ?
              asrc_crc8({cmd, 40'h0}, 16) : 8'h00};
            n_clk <= (cfg[`ASRC_HC_ONE] ? `ASRC_N_ONE : `ASRC_N_TWO)
              + (cfg[`ASRC_HC_CRCR] ? `ASRC_N_CRC : 7'd0)
              + (cfg[`ASRC_HC_RES] ? (cfg[`ASRC_HC_ONE] ?
                `ASRC_N_RES_ONE : `ASRC_N_RES_TWO) : 7'd0);
          end
        end
        ASRC_RUN:
        begin
          if (div == 8'(HALF - 1))
          begin
            div <= 8'h00;
            if (!sclk)
            begin
              sclk <= 1'b1;
              rxa <= {rxa[62:0], first_s[1]};
              rxb <= {rxb[30:0], second_s[1]};
              cnt <= cnt + 7'h01;
            end
            else
            begin
              sclk <= 1'b0;
              sdi <= tx[22];
              tx <= {tx[22:0], 1'b0};
              if (cnt == n_clk)
              begin
                cs_n <= 1'b1;
                state <= ASRC_GAP;
              end
            end
          end
          else
            div <= div + 8'h01;
        end
        ASRC_GAP:
        begin
          if (div == 8'(2 * HALF - 1))
          begin
            state <= ASRC_IDLE;
            busy <= 1'b0;
          end
          else
            div <= div + 8'h01;
        end
        default: state <= ASRC_IDLE;
      endcase
    end
  end

  assign link.cs_n = cs_n;
  assign link.sclk = sclk;
  assign link.sdi = sdi;
endmodule

// File: verif/asrc_link_chk.sv
`timescale 1ns/100ps
module asrc_link_chk #(
  parameter int HALF = 8
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic serial_out_first,
  input wire logic serial_out_first_oe,
  input wire logic serial_out_second,
  input wire logic serial_out_second_oe
);
  logic [7:0] hi_cnt;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Cycles of the current serial clock high phase
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sclk)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= hi_cnt + 8'h01;
  end
  chk_lanes_idle_off: assert property (
    cs_n [*7] |-> !serial_out_first_oe && !serial_out_second_oe)
    else $error("lane driven outside a frame");
  chk_lane_frame_on: assert property (
    $fell(cs_n) |-> ##[1:8] serial_out_first_oe)
    else $error("first lane not driven after frame start");
  chk_lane_bit_hold: assert property (
    $rose(sclk) |=> ($stable(serial_out_first)
      && $stable(serial_out_second)) [*2])
    else $error("lane bit changed at sampling clock rise");
  chk_lane_release: assert property (
    $rose(cs_n) |-> ##[1:8] !serial_out_first_oe && !serial_out_second_oe)
    else $error("lane not released after frame end");
  chk_sclk_idle_low: assert property (
    cs_n && $past(cs_n) |-> !sclk)
    else $error("serial clock active outside a frame");
  chk_sclk_high_len: assert property (
    $fell(sclk) |-> hi_cnt == 8'(HALF))
    else $error("serial clock high phase wrong length");
  chk_frame_gap_min: assert property (
    $rose(cs_n) |-> cs_n [*8])
    else $error("frame gap too short");
  chk_sdi_fall_only: assert property (
    $changed(sdi) |-> !sclk)
    else $error("command bit changed while clock high");
  cover property ($fell(cs_n));
  cover property ($rose(serial_out_second_oe));
  cover property ($fell(sclk) ##1 cs_n);
endmodule

// File: verif/adc_serial_readout_crc_tb.sv
`timescale 1ns/100ps
`include "asrc_defs.svh"
module adc_serial_readout_crc_tb;
  localparam int HALF_T = 8;
  localparam logic [55:0] V1 = 56'hab_cdef_0123_4567;
  localparam logic [55:0] V2 = 56'h5a_1e3c_96f0_8d27;
  localparam logic [1:0] OK = `ASRC_RESP_OK;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [13:0] ch_a = 14'h0, ch_b = 14'h0, ch_c = 14'h0, ch_d = 14'h0;
  logic sample_strobe, result_ready, write_reject;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int n_fail = 0, check_count = 0;
  int n_frames = 0, n_samp = 0, n_conv = 0, n_rej = 0;
  asrc_link_if link ();
  asrc_device #(.CONV_NS(100)) asrc_device_i (.aclk(aclk),
    .aresetn(aresetn), .link(link), .ch_a(ch_a), .ch_b(ch_b),
    .ch_c(ch_c), .ch_d(ch_d), .sample_strobe(sample_strobe),
    .result_ready(result_ready), .write_reject(write_reject));
  asrc_host #(.HALF(HALF_T)) asrc_host_i (.aclk(aclk), .aresetn(aresetn),
    .link(link), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  asrc_link_chk #(.HALF(HALF_T)) asrc_link_chk_i (.aclk(aclk),
    .aresetn(aresetn), .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi),
    .serial_out_first(link.serial_out_first),
    .serial_out_first_oe(link.serial_out_first_oe),
    .serial_out_second(link.serial_out_second),
    .serial_out_second_oe(link.serial_out_second_oe));
  always #12.5 aclk = ~aclk;
  // Pulse counters
  always @(posedge aclk)
  begin
    n_samp += int'(sample_strobe === 1'b1);
    n_conv += int'(result_ready === 1'b1);
    n_rej += int'(write_reject === 1'b1);
  end
  // Checksum of an n-bit left-aligned message
  function automatic logic [7:0] crc(input logic [55:0] m, input int n);
    logic [63:0] r;
    r = {m ^ {8'hff, 48'h0}, 8'h00};
    for (int i = 63; i >= 64 - n; i--)
      if (r[i])
        r[i -: 9] = r[i -: 9] ^ 9'h107;
    return r[63 - n -: 8];
  endfunction
  function automatic logic [23:0] regw(input logic [15:0] w);
    return {w, crc({w, 40'h0}, 16)};
  endfunction
  task automatic check(input string what, input logic [63:0] seen,
    input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic aw_t, w_t, aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d))
    begin
      @(negedge aclk);
      aw_t = (awready === 1'b1) && !aw_d;
      w_t = (wready === 1'b1) && !w_d;
      @(posedge aclk);
      awvalid <= !(aw_t || aw_d);
      wvalid <= !(w_t || w_d);
      aw_d = aw_d || aw_t;
      w_d = w_d || w_t;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    check("write response", 64'(bresp), 64'(er));
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    check("read response", 64'(rresp), 64'(er));
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic frame(input logic [15:0] cmd);
    logic [31:0] s;
    axi_wr(`ASRC_R_CMD, {16'h0, cmd}, OK);
    n_frames++;
    do axi_rd(`ASRC_R_STAT, s, OK); while (s[0] !== 1'b0);
  endtask
  // Top k of the last n bits received on a lane
  task automatic lane(input string what, input int n, input int k,
    input logic [63:0] exp, input logic sec);
    logic [31:0] hi, lo;
    logic [63:0] v;
    axi_rd(sec ? `ASRC_R_RXB : `ASRC_R_RXA_HI, hi, OK);
    axi_rd(`ASRC_R_RXA_LO, lo, OK);
    v = sec ? {32'h0, hi} : {hi, lo};
    v = (v >> (n - k)) & ((64'h1 << k) - 64'h1);
    check(what, v, exp);
  endtask
  task automatic set_ch(input logic [55:0] v);
    @(posedge aclk);
    {ch_a, ch_b, ch_c, ch_d} <= v;
  endtask
  task automatic test_done(input string t);
    $display("test %s done", t);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge aclk);
    n_fail++;
    $display("watchdog expired");
    complete_run();
  end
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(8'h18, rd, `ASRC_RESP_ERR);
    axi_wr(8'h18, 32'h0, `ASRC_RESP_ERR);
    test_done("access");
    set_ch(V1);
    frame(16'h0000);
    set_ch(V2);
    frame(16'h0000);
    lane("two lane A", 28, 28, {V1[55:42], V1[27:14]}, 1'b0);
    lane("two lane B", 28, 28, {V1[41:28], V1[13:0]}, 1'b1);
    set_ch(V1);
    frame(16'h6123);
    frame(16'h0000);
    lane("ignored read", 28, 28, {V1[55:42], V1[27:14]}, 1'b0);
    test_done("two lane");
    frame(16'h9010);
    axi_wr(`ASRC_R_CFG, 32'h2, OK);
    set_ch(V2);
    frame(16'h0000);
    frame(16'h0000);
    lane("crc two", 36, 36,
      {V2[55:42], V2[27:14], crc(V2, 56)}, 1'b0);
    frame(16'h4abc);
    frame(16'h0000);
    lane("reg read", 36, 24, regw(16'h4800), 1'b0);
    test_done("read checksum");
    frame(16'ha100);
    axi_wr(`ASRC_R_CFG, 32'h6, OK);
    set_ch(V1);
    frame(16'h0000);
    frame(16'h0000);
    lane("crc one", 64, 64, {V1, crc(V1, 56)}, 1'b0);
    test_done("single lane");
    frame(16'h9030);
    check("reject enable", 64'(n_rej), 64'h1);
    frame(16'h1000);
    frame(16'h0000);
    lane("cfg kept", 64, 24, regw(16'h1010), 1'b0);
    axi_wr(`ASRC_R_CFG, 32'h7, OK);
    frame(16'h9030);
    frame(16'h1000);
    frame(16'h0000);
    lane("cfg checked", 64, 24, regw(16'h1030), 1'b0);
    axi_wr(`ASRC_R_CFG, 32'h6, OK);
    frame(16'h9010);
    check("reject plain", 64'(n_rej), 64'h2);
    frame(16'h3000);
    frame(16'h0000);
    lane("alert flag", 64, 24, regw(16'h3200), 1'b0);
    axi_wr(`ASRC_R_CFG, 32'h7, OK);
    frame(16'h9010);
    frame(16'h1000);
    frame(16'h0000);
    lane("cfg cleared", 64, 24, regw(16'h1010), 1'b0);
    test_done("write checksum");
    axi_wr(`ASRC_R_CFG, 32'he, OK);
    set_ch(V2);
    frame(16'h0000);
    frame(16'h0000);
    lane("boost one", 64, 64, {V2[47:0], crc(V2, 56), 8'h00}, 1'b0);
    check("samples", 64'(n_samp), 64'(n_frames));
    check("conversions", 64'(n_conv), 64'(n_frames));
    test_done("boost");
    complete_run();
  end
endmodule
